// file: smcfg_cfg.svh
// Constants of the bus clock and configuration block.
// Assumes inclusion by bare name; definitions only.
`ifndef SMCFG_CFG_SVH
`define SMCFG_CFG_SVH
`define SMCFG_CFG_ADDR 8'hc1
`define SMCFG_CFG_RESET 8'h00
`define SMCFG_BIT_EN 7
`define SMCFG_BIT_INH 6
`define SMCFG_BIT_BUSY 5
`define SMCFG_BIT_EXT 4
`define SMCFG_BIT_TOE 3
`define SMCFG_BIT_FTE 2
`define SMCFG_SEL_HI 1
`define SMCFG_SEL_LO 0
`define SMCFG_HOLD_STD 4'h3
`define SMCFG_HOLD_EXT 4'hc
`define SMCFG_SETUP_STD 4'h1
`define SMCFG_SETUP_EXT 4'hb
`define SMCFG_LOW_OVF 2'h1
`define SMCFG_LOW_OVF_UNALIGNED 2'h2
`define SMCFG_HIGH_OVF 2'h2
`define SMCFG_FREE_OVF 4'hb
`endif

// file: smcfg_pkg.sv
// Types of the bus clock and configuration block.
// Assumes compilation before every module of the block.
package smcfg_pkg;
   typedef struct packed {
      logic scl;
      logic sda;
   } smcfg_pins_s;
   typedef enum logic [1:0] {
      st_idle,
      st_low,
      st_high_wait,
      st_high
   } smcfg_state_e;
   typedef logic [3:0] smcfg_cnt_t;
endpackage

// file: smcfg_sync.sv
// Two-stage synchroniser for pins entering the system clock domain.
// Assumes asynchronous inputs; output is usable by any logic.
`timescale 1ns/1ns
module smcfg_sync #(
   parameter int W = 2
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_r;
   // Idle bus level is high, so reset to ones
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         meta_r <= '1;
         sync_out <= '1;
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule

// file: smcfg_top.sv
// Bus clock generation, SDA timing and configuration register.
// Assumes timer overflow pulses on sys_clk, pins open-drain outside.
`timescale 1ns/1ns
`include "smcfg_cfg.svh"
module smcfg_top
   import smcfg_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic [3:0] tmr_ovf,
   input wire logic master_run,
   input wire logic bit_stall,
   input wire logic sda_next,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic scl_oe,
   output logic sda_out,
   output logic sda_oe,
   output logic tmr_lowto_reload,
   output logic stop_flag_set,
   output logic iface_irq,
   output logic slave_nack_all
);
   // ****************************************
   // Configuration register
   // ****************************************
   logic [7:0] cfg_r;
   logic busy_r;
   logic [7:0] rdata_nxt;
   wire cfg_hit = (sfr_addr == `SMCFG_CFG_ADDR);
   wire iface_enable = cfg_r[`SMCFG_BIT_EN];
   wire slave_inhibit = cfg_r[`SMCFG_BIT_INH];
   wire sda_hold_extend = cfg_r[`SMCFG_BIT_EXT];
   wire low_timeout_enable = cfg_r[`SMCFG_BIT_TOE];
   wire free_timeout_enable = cfg_r[`SMCFG_BIT_FTE];
   wire [1:0] clk_src_sel = {cfg_r[`SMCFG_SEL_HI], cfg_r[`SMCFG_SEL_LO]};
   always_comb begin
      rdata_nxt = cfg_r;
      rdata_nxt[`SMCFG_BIT_BUSY] = busy_r;
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cfg_r <= `SMCFG_CFG_RESET;
      end else if (sfr_wr && cfg_hit) begin
         cfg_r <= sfr_wdata;
         cfg_r[`SMCFG_BIT_BUSY] <= 1'b0;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sfr_rdata <= `SMCFG_CFG_RESET;
      end else begin
         sfr_rdata <= cfg_hit ? rdata_nxt : `SMCFG_CFG_RESET;
      end
   end

   // ****************************************
   // Pin sampling and bus conditions
   // ****************************************
   smcfg_pins_s pin_raw, pin_s, pin_q_r;
   assign pin_raw = '{scl: scl_in, sda: sda_in};
   smcfg_sync #(.W(2)) u_pin_sync (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .async_in(pin_raw),
      .sync_out(pin_s)
   );
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pin_q_r <= '1;
      end else begin
         pin_q_r <= pin_s;
      end
   end
   // START and STOP watched only while enabled
   wire start_det = iface_enable && pin_s.scl && pin_q_r.scl
                    && pin_q_r.sda && !pin_s.sda;
   wire stop_det = iface_enable && pin_s.scl && pin_q_r.scl
                   && !pin_q_r.sda && pin_s.sda;
   wire scl_fell = pin_q_r.scl && !pin_s.scl;
   wire ovf_sel = tmr_ovf[clk_src_sel];

   // ****************************************
   // Free timeout, busy and slave inhibit
   // ****************************************
   smcfg_cnt_t free_cnt_r;
   logic free_hit;
   logic inh_act_r;
   wire both_high = pin_s.scl && pin_s.sda;
   wire free_run = iface_enable && free_timeout_enable && both_high;
   // Fires once per idle stretch; count saturates at the threshold
   assign free_hit = free_run && ovf_sel
                     && (free_cnt_r == `SMCFG_FREE_OVF - 4'h1);
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !free_run) begin
         free_cnt_r <= '0;
      end else if (ovf_sel && free_cnt_r != `SMCFG_FREE_OVF) begin
         free_cnt_r <= free_cnt_r + 4'h1;
      end
   end
   assign stop_flag_set = stop_det || free_hit;
   assign iface_irq = stop_det || free_hit;
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !iface_enable) begin
         busy_r <= 1'b0;
      end else if (stop_flag_set) begin
         busy_r <= 1'b0;
      end else if (start_det || scl_oe) begin
         busy_r <= 1'b1;
      end
   end
   // Inhibit sampled at START so current transfer keeps its NACK setting
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !iface_enable) begin
         inh_act_r <= 1'b0;
      end else if (start_det) begin
         inh_act_r <= slave_inhibit;
      end
   end
   assign slave_nack_all = inh_act_r;
   assign tmr_lowto_reload = !(iface_enable && low_timeout_enable
                               && !pin_s.scl);

   // ****************************************
   // Master SCL generator
   // ****************************************
   smcfg_state_e state_r, state_nxt;
   logic [1:0] ovf_cnt_r, ovf_cnt_nxt;
   logic aligned_r, aligned_nxt;
   logic setup_ok;
   wire [1:0] low_need = aligned_r ? `SMCFG_LOW_OVF
                                   : `SMCFG_LOW_OVF_UNALIGNED;
   wire low_done = ovf_sel && (ovf_cnt_r + 2'h1 >= low_need);
   wire high_done = ovf_sel
                    && (ovf_cnt_r + 2'h1 == `SMCFG_HIGH_OVF);
   always_comb begin
      state_nxt = state_r;
      ovf_cnt_nxt = ovf_sel ? ovf_cnt_r + 2'h1 : ovf_cnt_r;
      aligned_nxt = aligned_r;
      case (state_r)
         st_idle: begin
            ovf_cnt_nxt = '0;
            if (master_run && ovf_sel) begin
               state_nxt = st_low;
               aligned_nxt = 1'b1;
            end
         end
         st_low: begin
            // Overflow count saturates while stall or setup holds SCL
            if (low_done) begin
               ovf_cnt_nxt = low_need;
            end
            if ((ovf_cnt_r >= low_need || low_done) && setup_ok
                && !bit_stall) begin
               state_nxt = st_high_wait;
               ovf_cnt_nxt = '0;
            end
         end
         st_high_wait: begin
            ovf_cnt_nxt = '0;
            if (pin_s.scl) begin
               state_nxt = st_high;
            end
         end
         st_high: begin
            if (!pin_s.scl) begin
               state_nxt = st_low;
               ovf_cnt_nxt = '0;
               aligned_nxt = 1'b0;
            end else if (high_done) begin
               state_nxt = st_low;
               ovf_cnt_nxt = '0;
               aligned_nxt = 1'b1;
            end
         end
         default: begin
            state_nxt = st_idle;
            ovf_cnt_nxt = '0;
         end
      endcase
      if (!master_run && state_r != st_low) begin
         state_nxt = st_idle;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !iface_enable) begin
         state_r <= st_idle;
         ovf_cnt_r <= '0;
         aligned_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         ovf_cnt_r <= ovf_cnt_nxt;
         aligned_r <= aligned_nxt;
      end
   end
   assign scl_out = 1'b0;
   assign scl_oe = (state_r == st_low);

   // ****************************************
   // SDA setup and hold timing
   // ****************************************
   // Sync delay only lengthens hold, never shortens it
   smcfg_cnt_t hold_cnt_r, setup_cnt_r;
   logic sda_r;
   wire [3:0] hold_need = sda_hold_extend ? `SMCFG_HOLD_EXT
                                          : `SMCFG_HOLD_STD;
   wire [3:0] setup_need = sda_hold_extend ? `SMCFG_SETUP_EXT
                                           : `SMCFG_SETUP_STD;
   wire hold_done = !pin_s.scl && !scl_fell && hold_cnt_r >= hold_need;
   wire sda_load = hold_done && (sda_next != sda_r);
   assign setup_ok = !sda_load && setup_cnt_r >= setup_need;
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !iface_enable || scl_fell) begin
         hold_cnt_r <= '0;
      end else if (!pin_s.scl && hold_cnt_r != 4'hf) begin
         hold_cnt_r <= hold_cnt_r + 4'h1;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !iface_enable) begin
         sda_r <= 1'b1;
         setup_cnt_r <= '0;
      end else if (sda_load) begin
         sda_r <= sda_next;
         setup_cnt_r <= '0;
      end else if (setup_cnt_r != 4'hf) begin
         setup_cnt_r <= setup_cnt_r + 4'h1;
      end
   end
   assign sda_out = 1'b0;
   assign sda_oe = !sda_r;

   // ****************************************
   // Checks
   // ****************************************
   sequence s_high_entered;
      state_r == st_high_wait ##1 state_r == st_high;
   endsequence
   sequence s_low_leave;
      state_r == st_low ##1 state_r == st_high_wait;
   endsequence
   chk_low_setup: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      s_low_leave |-> $past(setup_cnt_r) >= $past(setup_need))
      else $error("SCL released before SDA setup");
   chk_low_stall: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      (state_r == st_low && bit_stall) |=> state_r != st_high_wait)
      else $error("SCL released during stall");
   chk_high_twice: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      s_high_entered ##0 (pin_s.scl && !ovf_sel) [*2] |-> state_r == st_high)
      else $error("High phase ended early");
   chk_high_leave: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      ($past(state_r) == st_high && state_r == st_low)
      |-> !$past(pin_s.scl) || ($past(ovf_sel)
      && $past(ovf_cnt_r) == 2'h1))
      else $error("High phase left without cause");
   chk_sda_hold: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      (iface_enable && $changed(sda_r)) |-> $past(hold_cnt_r)
      >= $past(hold_need))
      else $error("SDA changed inside hold window");
   chk_reload_low: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      (iface_enable && low_timeout_enable) |-> tmr_lowto_reload
      == pin_s.scl)
      else $error("Timeout timer reload wrong");
   chk_free_stop: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      free_hit |-> stop_flag_set && iface_irq ##1 !busy_r)
      else $error("Free timeout not treated as stop");
   // Read data lags busy by one register stage
   chk_busy_clear: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      stop_det |=> !busy_r ##1 !sfr_rdata[`SMCFG_BIT_BUSY])
      else $error("Busy not cleared on stop");
   chk_inh_start: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      (start_det && iface_enable) |=> slave_nack_all
      == $past(slave_inhibit))
      else $error("Inhibit not taken at start");
   chk_disable_idle: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      !iface_enable |=> !scl_oe && !sda_oe && !busy_r)
      else $error("Disabled interface drives bus");
   chk_busy_ro: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      cfg_r[`SMCFG_BIT_BUSY] == 1'b0)
      else $error("Busy position stored a write");
   chk_free_count: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      free_hit |-> free_run && free_cnt_r == `SMCFG_FREE_OVF - 4'h1
      ##1 free_cnt_r == `SMCFG_FREE_OVF)
      else $error("Free timeout count wrong");
endmodule

// file: smcfg_far_end.sv
// Far side of the two-wire bus: pull-ups and a slow remote party.
// Assumes the bench calls its tasks; released lines float high.
`timescale 1ns/1ns
module smcfg_far_end (
   input wire logic scl_oe,
   input wire logic sda_oe,
   output logic scl_in,
   output logic sda_in
);
   // ****************
   // Wired-AND lines
   // ****************
   logic scl_low = 1'b0;
   logic sda_low = 1'b0;
   assign scl_in = !(scl_oe || scl_low);
   assign sda_in = !(sda_oe || sda_low);
   // Slow slave stretch
   task automatic stretch(input int ns);
      scl_low = 1'b1;
      #(ns);
      scl_low = 1'b0;
   endtask
   task automatic start();
      sda_low = 1'b1;
      #62;
   endtask
   // One 125 ns clock, then STOP; clock idles high outside frames
   task automatic stop();
      scl_low = 1'b1;
      #63;
      scl_low = 1'b0;
      #62;
      sda_low = 1'b0;
      #62;
   endtask
endmodule

// file: smbus_config_timing_test.sv
// Bench for the bus clock and configuration block.
// Assumes the far-end model and timer pulses made here.
`timescale 1ns/1ns
module smbus_config_timing_test;
   logic sys_clk, sys_rst = 1'b1, sfr_wr = 1'b0, master_run = 1'b0;
   logic bit_stall = 1'b0, sda_next = 1'b1, ovf_on = 1'b0, oe_q, sda_q;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, d;
   logic [3:0] tmr_ovf = 4'h0;
   logic [1:0] sel = 2'h0;
   logic scl_in, sda_in, scl_oe, sda_oe, scl_q = 1'b1;
   logic tmr_lowto_reload, stop_flag_set, iface_irq, slave_nack_all;
   int fail_count, comparisons, stops, irqs, novf, ovf_cnt, cyc;
   int t_fall, t_chg, hmin, smin, n, lo, hi, base, i;
   localparam int P = 20;
   smcfg_top smcfg_top_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata), .tmr_ovf(tmr_ovf), .master_run(master_run),
      .bit_stall(bit_stall), .sda_next(sda_next), .scl_in(scl_in),
      .sda_in(sda_in), .scl_out(), .scl_oe(scl_oe), .sda_out(),
      .sda_oe(sda_oe), .tmr_lowto_reload(tmr_lowto_reload),
      .stop_flag_set(stop_flag_set), .iface_irq(iface_irq),
      .slave_nack_all(slave_nack_all));
   smcfg_far_end smcfg_far_end_inst (.scl_oe(scl_oe), .sda_oe(sda_oe),
      .scl_in(scl_in), .sda_in(sda_in));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // ****************
   // Timers and monitors
   // ****************
   // Unselected timers pulse faster, so a wrong select shows
   always @(posedge sys_clk) begin
      ovf_cnt <= (ovf_cnt + 1) % P;
      tmr_ovf <= !ovf_on ? 4'h0 : ovf_cnt == 0 ? 4'h1 << sel :
         ovf_cnt % 4 == 2 ? ~(4'h1 << sel) : 4'h0;
      if (ovf_on && ovf_cnt == 0) novf++;
      if (stop_flag_set === 1'b1) stops++;
      if (iface_irq === 1'b1) irqs++;
      oe_q <= scl_oe;
      if (scl_oe && !oe_q) sda_next <= ~sda_next;
      cyc++;
      // Compare with last cycle's levels before storing new ones
      if (scl_q && !scl_in) t_fall = cyc;
      if (sda_oe !== sda_q) begin
         hmin = (cyc - t_fall < hmin) ? cyc - t_fall : hmin;
         t_chg = cyc;
      end
      if (!scl_q && scl_in) smin = (cyc - t_chg < smin) ? cyc - t_chg : smin;
      scl_q = scl_in;
      sda_q = sda_oe;
   end
   // ****************
   // Tasks
   // ****************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      sfr_addr <= a;
      sfr_wdata <= v;
      sfr_wr <= 1'b1;
      @(posedge sys_clk);
      sfr_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      sfr_addr <= a;
      repeat (2) @(posedge sys_clk);
      #1 v = sfr_rdata;
   endtask
   task automatic phase(input logic lvl, output int c);
      c = 0;
      while (scl_oe !== lvl && c < 999) begin
         @(posedge sys_clk);
         #1 c++;
      end
   endtask
   task automatic wrap_up();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Whole plan needs about 2k cycles; allow 25 times that
   initial begin
      #500000;
      fail_count++;
      wrap_up();
   end
   // ****************
   // Tests
   // ****************
   initial begin
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(8'hc1, d);
      check(d, 8'h00);
      check(tmr_lowto_reload, 1'b1);
      wr(8'hc1, 8'hff);
      rd(8'hc1, d);
      check(d, 8'hdf);
      rd(8'h10, d);
      check(d, 8'h00);
      wr(8'hc1, 8'h80);
      smcfg_far_end_inst.start();
      rd(8'hc1, d);
      check(d, 8'ha0);
      n = stops;
      smcfg_far_end_inst.stop();
      rd(8'hc1, d);
      check(d, 8'h80);
      check(stops - n, 1);
      check(irqs, stops);
      wr(8'hc1, 8'h00);
      smcfg_far_end_inst.start();
      smcfg_far_end_inst.stop();
      repeat (4) @(posedge sys_clk);
      check(stops - n, 1);
      wr(8'hc1, 8'hc0);
      repeat (4) @(posedge sys_clk);
      check(slave_nack_all, 1'b0);
      smcfg_far_end_inst.start();
      check(slave_nack_all, 1'b1);
      smcfg_far_end_inst.stop();
      wr(8'hc1, 8'h88);
      fork
         smcfg_far_end_inst.stretch(300);
         begin
            repeat (10) @(posedge sys_clk);
            check(tmr_lowto_reload, 1'b0);
         end
      join
      repeat (5) @(posedge sys_clk);
      check(tmr_lowto_reload, 1'b1);
      wr(8'hc1, 8'h08);
      for (int s = 0; s < 4; s++) begin
         ovf_on = 1'b0;
         sel = 2'(s);
         wr(8'hc1, 8'h84 | 8'(s));
         smcfg_far_end_inst.stretch(50);
         repeat (5) @(posedge sys_clk);
         base = novf;
         n = stops;
         ovf_on = 1'b1;
         for (i = 0; i < 500 && stops == n; i++) begin
            @(posedge sys_clk);
            #1;
         end
         ovf_on = 1'b0;
         check(8'(novf - base), 8'd11);
         check(irqs, stops);
      end
      sel = 2'h0;
      ovf_on = 1'b1;
      wr(8'hc1, 8'h80);
      master_run <= 1'b1;
      phase(1'b1, n);
      phase(1'b0, lo);
      phase(1'b1, hi);
      check(lo >= P && lo <= P + 2, 1'b1);
      check(hi >= 2 * P - 1 && hi <= 2 * P + 3, 1'b1);
      check(lo + hi >= 3 * P - 1 && lo + hi <= 3 * P + 4, 1'b1);
      fork
         smcfg_far_end_inst.stretch(700);
      join_none
      phase(1'b0, lo);
      phase(1'b1, hi);
      check(lo + hi >= P + 73 && lo + hi <= 2 * P + 76, 1'b1);
      @(posedge sys_clk);
      bit_stall <= 1'b1;
      repeat (60) @(posedge sys_clk);
      bit_stall <= 1'b0;
      phase(1'b0, lo);
      check(lo <= P + 3, 1'b1);
      for (int m = 0; m < 2; m++) begin
         wr(8'hc1, m ? 8'h90 : 8'h80);
         phase(1'b0, n);
         phase(1'b1, n);
         hmin = 99;
         smin = 99;
         repeat (3) begin
            phase(1'b0, n);
            phase(1'b1, n);
         end
         check(hmin >= (m ? 12 : 3), 1'b1);
         check(smin >= (m ? 11 : 1), 1'b1);
      end
      master_run <= 1'b0;
      wrap_up();
   end
endmodule
